// File: rtl/dct_top.v
/*
 * Dual counter/timer control: 8-bit and 16-bit counters with transmit
 * (normal, ping-pong, forced, combined output) and demodulation modes.
 * Assumes a single-cycle register port with read data one cycle later,
 * and asynchronous edge input pins.
 */
// Implementation choice: the address-and-strobe port.
// Notes on behaviour
// - Transmit mode: logic field combines both outputs as AND/OR/NOR/NAND.
// - Demodulation mode: logic field selects reported edge polarity.
// - Submode picks ping-pong or normal; writing normal ends ping-pong.
// - Submode 10 forces sixteen-bit output low, 11 forces it high.
// - Demodulation submode sets minimum pulse width; narrower glitches drop.
// - Eight-bit output takes its initial-level bit when counting starts.
// - Disabled eight-bit output holds inverse of its initial-level bit.
// - Sixteen-bit output likewise, in normal and ping-pong submodes only.
// - Demodulation: shared bit 1 is rising-edge flag, write 1 clears.
// - Demodulation: shared bit 0 is falling-edge flag, write 1 clears.
// - Edge detector watches one of two pins, pulses pos or neg line.
// - Glitch filter width chosen by shared bits 3 and 2.
// - Ping-pong: hardware alternately sets and clears both run bits.
// - Each counter sets its time-out flag at every terminal count.
// - Eight-bit control bit 0 routes its output to its pin.
// - Sixteen-bit control bit 0 routes its output to its pin.
// - Shared bit 6 drives combined output on a third pin, in transmit mode only.
// - Eight-bit control bit 2 enables the data-capture request.
// - Sync register bits 4..0 read all ones, writes ignored.
// - Sync mode aligns first eight-bit carrier pulse to sixteen-bit signal.
// - Sync mode bit resets to disabled.
// - Eight-bit counter reloads from readable high and low hold bytes.
`timescale 1ns/1ps
`include "dct_map.vh"
module dct_top
(
   input  wire                   i_clk_sys,
   input  wire                   i_srst,
   input  wire                   i_ce,
   input  wire [`DCT_ADDR_W-1:0] i_addr,
   input  wire [7:0]             i_wr_data,
   input  wire                   i_wr,
   input  wire                   i_rd,
   output reg  [7:0]             o_rd_data,
   input  wire                   i_edge_pin_a,
   input  wire                   i_edge_pin_b,
   output wire                   o_eight_counter_pin,
   output wire                   o_sixteen_counter_pin,
   output wire                   o_combined_output_pin,
   output wire                   o_eight_counter_pin_oe_n,
   output wire                   o_sixteen_counter_pin_oe_n,
   output wire                   o_combined_output_pin_oe_n,
   output reg                    o_capture_req
);

   // ************************************************************
   // Functions
   // ************************************************************
   function [1:0] fld2;
      input [7:0] v;
      input integer lo;
      begin
         fld2 = {v[lo + 1], v[lo]};
      end
   endfunction

   function comb_logic;
      input [1:0] sel;
      input       a;
      input       b;
      begin
         case (sel)
            `DCT_LOG_AND: comb_logic = a & b;
            `DCT_LOG_OR:  comb_logic = a | b;
            `DCT_LOG_NOR: comb_logic = ~(a | b);
            default:      comb_logic = ~(a & b);
         endcase
      end
   endfunction

   // ************************************************************
   // State
   // ************************************************************
   reg [7:0]  ctl8_reg;
   reg [7:0]  shared_reg;
   reg [7:0]  ctl16_reg;
   reg        sync_en_reg;
   reg [7:0]  hold8_lo_reg;
   reg [7:0]  hold8_hi_reg;
   reg [7:0]  hold16_lo_reg;
   reg [7:0]  hold16_hi_reg;
   reg [7:0]  cnt8_reg;
   reg [15:0] cnt16_reg;
   reg [2:0]  pre8_reg;
   reg        out8_reg;
   reg        out16_reg;
   reg        run8_q_reg;
   reg        run16_q_reg;
   reg        pp_active_reg;
   reg        sync_wait_reg;
   reg        out16_q_reg;
   reg        comb_reg;
   reg        pin8_reg;
   reg        pin16_reg;

   wire       demod    = shared_reg[`DCT_B_DEMOD];
   wire [1:0] logic_f  = fld2(shared_reg, `DCT_B_LOGIC_LO);
   wire [1:0] sub_f    = fld2(shared_reg, `DCT_B_SUB_LO);
   wire [1:0] clk_f    = fld2(ctl8_reg, `DCT_B_CLKSEL_LO);
   wire       run8     = ctl8_reg[`DCT_B_RUN];
   wire       run16    = ctl16_reg[`DCT_B_RUN];
   wire       lvl8     = shared_reg[`DCT_B_LVL8];
   wire       lvl16    = shared_reg[`DCT_B_LVL16];
   wire       pin_sel  = ctl16_reg[`DCT_B_PINSEL];

   wire       wr_ctl8   = i_wr & (i_addr == `DCT_OFS_CTL8);
   wire       wr_shared = i_wr & (i_addr == `DCT_OFS_SHARED);
   wire       wr_ctl16  = i_wr & (i_addr == `DCT_OFS_CTL16);
   wire       wr_sync   = i_wr & (i_addr == `DCT_OFS_SYNC);

   // ************************************************************
   // Edge input path
   // ************************************************************
   wire lvl_a;
   wire lvl_b;
   wire pos_edge;
   wire neg_edge;

   dct_sync3 u_sync_a
   (
      .i_clk_sys (i_clk_sys),
      .i_srst    (i_srst),
      .i_ce      (i_ce),
      .i_pin     (i_edge_pin_a),
      .o_level   (lvl_a)
   );

   dct_sync3 u_sync_b
   (
      .i_clk_sys (i_clk_sys),
      .i_srst    (i_srst),
      .i_ce      (i_ce),
      .i_pin     (i_edge_pin_b),
      .o_level   (lvl_b)
   );

   dct_glitch_edge u_filter
   (
      .i_clk_sys   (i_clk_sys),
      .i_srst      (i_srst),
      .i_ce        (i_ce),
      .i_level     (pin_sel ? lvl_b : lvl_a),
      .i_width_sel (sub_f),
      .o_pos_edge  (pos_edge),
      .o_neg_edge  (neg_edge)
   );

   // Logic field doubles as the edge polarity in demodulation
   wire want_rise = (logic_f != `DCT_EDGE_FALL);
   wire want_fall = (logic_f != `DCT_EDGE_RISE);
   wire rise_hit  = demod & pos_edge & want_rise;
   wire fall_hit  = demod & neg_edge & want_fall;

   // ************************************************************
   // Counter ticks and terminal counts
   // ************************************************************
   wire tick8 = ~|(pre8_reg & ((3'h1 << clk_f) - 3'h1));
   wire go8   = ~demod & run8 & run8_q_reg & ~sync_wait_reg;
   wire go16  = ~demod & run16 & run16_q_reg;
   wire tc8   = go8 & tick8 & (cnt8_reg == 8'h00);
   wire tc16  = go16 & (cnt16_reg == 16'h0000);
   wire pp    = pp_active_reg & (sub_f == `DCT_SUB_PINGPONG);
   wire sync_rise = out16_reg & ~out16_q_reg;

   // ************************************************************
   // Control registers
   // ************************************************************
   always @(posedge i_clk_sys)
   begin
      if (i_srst)
      begin
         ctl8_reg      <= `DCT_RST_BYTE;
         shared_reg    <= `DCT_RST_BYTE;
         ctl16_reg     <= `DCT_RST_BYTE;
         sync_en_reg   <= 1'b0;
         hold8_lo_reg  <= `DCT_RST_BYTE;
         hold8_hi_reg  <= `DCT_RST_BYTE;
         hold16_lo_reg <= `DCT_RST_BYTE;
         hold16_hi_reg <= `DCT_RST_BYTE;
         pp_active_reg <= 1'b0;
      end
      else if (i_ce)
      begin
         if (wr_ctl8)
         begin
            ctl8_reg[7:6] <= i_wr_data[7:6];
            ctl8_reg[4:0] <= i_wr_data[4:0];
         end
         if (wr_ctl16)
         begin
            ctl16_reg[7:6] <= i_wr_data[7:6];
            ctl16_reg[4:0] <= i_wr_data[4:0];
         end
         if (wr_sync)
         begin
            ctl16_reg[`DCT_B_RUN] <= i_wr_data[`DCT_B_SYNC_RUN16];
            ctl8_reg[`DCT_B_RUN]  <= i_wr_data[`DCT_B_SYNC_RUN8];
            sync_en_reg           <= i_wr_data[`DCT_B_SYNC_EN];
         end
         if (wr_shared)
         begin
            shared_reg[7:2] <= i_wr_data[7:2];
            // Flag bits are write-one-to-clear only in demodulation
            if (!i_wr_data[`DCT_B_DEMOD] && !demod)
               shared_reg[1:0] <= i_wr_data[1:0];
            else if (i_wr_data[`DCT_B_DEMOD] != demod)
               shared_reg[1:0] <= 2'h0;
            else
               shared_reg[1:0] <= shared_reg[1:0] & ~i_wr_data[1:0];
            if (fld2(i_wr_data, `DCT_B_SUB_LO) == `DCT_SUB_PINGPONG)
               pp_active_reg <= 1'b1;
            else
               pp_active_reg <= 1'b0;
         end
         if (i_wr && i_addr == `DCT_OFS_HOLD8_LO)
            hold8_lo_reg <= i_wr_data;
         if (i_wr && i_addr == `DCT_OFS_HOLD8_HI)
            hold8_hi_reg <= i_wr_data;
         if (i_wr && i_addr == `DCT_OFS_HOLD16_LO)
            hold16_lo_reg <= i_wr_data;
         if (i_wr && i_addr == `DCT_OFS_HOLD16_HI)
            hold16_hi_reg <= i_wr_data;

         // Hardware sets win over a same-cycle clear
         if (rise_hit)
            shared_reg[`DCT_B_LVL8] <= 1'b1;
         if (fall_hit)
            shared_reg[`DCT_B_LVL16] <= 1'b1;
         if (wr_ctl8 && i_wr_data[`DCT_B_TIMEOUT])
            ctl8_reg[`DCT_B_TIMEOUT] <= 1'b0;
         if (wr_ctl16 && i_wr_data[`DCT_B_TIMEOUT])
            ctl16_reg[`DCT_B_TIMEOUT] <= 1'b0;
         if (tc8)
            ctl8_reg[`DCT_B_TIMEOUT] <= 1'b1;
         if (tc16)
            ctl16_reg[`DCT_B_TIMEOUT] <= 1'b1;

         // Ping-pong hands the run bit to the other counter
         if (pp && tc8)
         begin
            ctl8_reg[`DCT_B_RUN]  <= 1'b0;
            ctl16_reg[`DCT_B_RUN] <= 1'b1;
         end
         else if (pp && tc16)
         begin
            ctl16_reg[`DCT_B_RUN] <= 1'b0;
            ctl8_reg[`DCT_B_RUN]  <= 1'b1;
         end
         else
         begin
            if (tc8 && ctl8_reg[`DCT_B_SINGLE])
               ctl8_reg[`DCT_B_RUN] <= 1'b0;
            if (tc16 && ctl16_reg[`DCT_B_SINGLE])
               ctl16_reg[`DCT_B_RUN] <= 1'b0;
         end
      end
   end

   // ************************************************************
   // Counters and output levels
   // ************************************************************
   always @(posedge i_clk_sys)
   begin
      if (i_srst)
      begin
         cnt8_reg      <= 8'h00;
         cnt16_reg     <= 16'h0000;
         pre8_reg      <= 3'h0;
         out8_reg      <= 1'b1;
         out16_reg     <= 1'b1;
         run8_q_reg    <= 1'b0;
         run16_q_reg   <= 1'b0;
         sync_wait_reg <= 1'b0;
         out16_q_reg   <= 1'b1;
      end
      else if (i_ce)
      begin
         run8_q_reg  <= run8;
         run16_q_reg <= run16;
         out16_q_reg <= out16_reg;
         pre8_reg    <= go8 ? pre8_reg + 3'h1 : 3'h0;

         if (!run8)
            out8_reg <= ~lvl8;
         else if (!run8_q_reg)
         begin
            // Start: jump to initial level, load matching hold byte
            out8_reg      <= lvl8;
            cnt8_reg      <= lvl8 ? hold8_hi_reg : hold8_lo_reg;
            sync_wait_reg <= sync_en_reg;
         end
         else if (sync_wait_reg)
         begin
            // Hold first carrier pulse until the 16-bit signal rises
            if (sync_rise)
               sync_wait_reg <= 1'b0;
         end
         else if (tc8)
         begin
            out8_reg <= ~out8_reg;
            cnt8_reg <= out8_reg ? hold8_lo_reg : hold8_hi_reg;
         end
         else if (go8 && tick8)
            cnt8_reg <= cnt8_reg - 8'h01;

         if (sub_f == `DCT_SUB_FORCE0)
            out16_reg <= 1'b0;
         else if (sub_f == `DCT_SUB_FORCE1)
            out16_reg <= 1'b1;
         else if (!run16)
            out16_reg <= ~lvl16;
         else if (!run16_q_reg)
         begin
            out16_reg <= lvl16;
            cnt16_reg <= {hold16_hi_reg, hold16_lo_reg};
         end
         else if (tc16)
         begin
            out16_reg <= ~out16_reg;
            cnt16_reg <= {hold16_hi_reg, hold16_lo_reg};
         end
         else if (go16)
            cnt16_reg <= cnt16_reg - 16'h0001;
      end
   end

   // ************************************************************
   // Output pins and capture request
   // ************************************************************
   always @(posedge i_clk_sys)
   begin
      if (i_srst)
      begin
         comb_reg      <= 1'b0;
         pin8_reg      <= 1'b0;
         pin16_reg     <= 1'b0;
         o_capture_req <= 1'b0;
      end
      else if (i_ce)
      begin
         comb_reg  <= comb_logic(logic_f, out8_reg, out16_reg);
         pin8_reg  <= out8_reg;
         pin16_reg <= out16_reg;
         // One-cycle pulse request; the interrupt controller lives elsewhere
         o_capture_req <= ctl8_reg[`DCT_B_CAPMASK] & (rise_hit | fall_hit);
      end
   end

   assign o_eight_counter_pin        = pin8_reg;
   assign o_sixteen_counter_pin      = pin16_reg;
   assign o_combined_output_pin      = comb_reg;
   assign o_eight_counter_pin_oe_n   = ~ctl8_reg[`DCT_B_PINEN];
   assign o_sixteen_counter_pin_oe_n = ~ctl16_reg[`DCT_B_PINEN];
   // Combined pin only meaningful in transmit mode
   assign o_combined_output_pin_oe_n =
      ~(shared_reg[`DCT_B_COMBEN] & ~demod);

   // ************************************************************
   // Register read port
   // ************************************************************
   always @(posedge i_clk_sys)
   begin
      if (i_srst)
         o_rd_data <= 8'h00;
      else if (i_ce && i_rd)
      begin
         if (i_addr == `DCT_OFS_CTL8)
            o_rd_data <= ctl8_reg;
         else if (i_addr == `DCT_OFS_SHARED)
            o_rd_data <= shared_reg;
         else if (i_addr == `DCT_OFS_CTL16)
            o_rd_data <= ctl16_reg;
         else if (i_addr == `DCT_OFS_SYNC)
            o_rd_data <= {run16, run8, sync_en_reg,
                          `DCT_RESERVED_RD};
         else if (i_addr == `DCT_OFS_HOLD8_LO)
            o_rd_data <= hold8_lo_reg;
         else if (i_addr == `DCT_OFS_HOLD8_HI)
            o_rd_data <= hold8_hi_reg;
         else if (i_addr == `DCT_OFS_HOLD16_LO)
            o_rd_data <= hold16_lo_reg;
         else if (i_addr == `DCT_OFS_HOLD16_HI)
            o_rd_data <= hold16_hi_reg;
         else
            o_rd_data <= 8'h00;
      end
   end

endmodule

// File: shared/dct_map.vh
/*
 * Register map, field positions, reset values and filter widths of the
 * dual counter/timer control block.
 * Assumes an 8-bit register port with byte offsets as given here.
 */
`ifndef DCT_MAP_VH
`define DCT_MAP_VH

// ************************************************************
// Register offsets
// ************************************************************
`define DCT_ADDR_W          4
`define DCT_OFS_CTL8        4'h0
`define DCT_OFS_SHARED      4'h1
`define DCT_OFS_CTL16       4'h2
`define DCT_OFS_SYNC        4'h3
`define DCT_OFS_HOLD8_LO    4'h4
`define DCT_OFS_HOLD8_HI    4'h5
`define DCT_OFS_HOLD16_LO   4'h6
`define DCT_OFS_HOLD16_HI   4'h7

// ************************************************************
// Field positions
// ************************************************************
`define DCT_B_RUN           7
`define DCT_B_SINGLE        6
`define DCT_B_TIMEOUT       5
`define DCT_B_CLKSEL_HI     4
`define DCT_B_CLKSEL_LO     3
`define DCT_B_CAPMASK       2
`define DCT_B_PINSEL        1
`define DCT_B_PINEN         0
`define DCT_B_DEMOD         7
`define DCT_B_COMBEN        6
`define DCT_B_LOGIC_HI      5
`define DCT_B_LOGIC_LO      4
`define DCT_B_SUB_HI        3
`define DCT_B_SUB_LO        2
`define DCT_B_LVL8          1
`define DCT_B_LVL16         0
`define DCT_B_SYNC_RUN16    7
`define DCT_B_SYNC_RUN8     6
`define DCT_B_SYNC_EN       5

// ************************************************************
// Encodings and reset values
// ************************************************************
`define DCT_SUB_NORMAL      2'h0
`define DCT_SUB_PINGPONG    2'h1
`define DCT_SUB_FORCE0      2'h2
`define DCT_SUB_FORCE1      2'h3
`define DCT_LOG_AND         2'h0
`define DCT_LOG_OR          2'h1
`define DCT_LOG_NOR         2'h2
`define DCT_LOG_NAND        2'h3
`define DCT_EDGE_FALL       2'h0
`define DCT_EDGE_RISE       2'h1
`define DCT_RESERVED_RD     5'h1f
`define DCT_RST_BYTE        8'h00

// ************************************************************
// Glitch filter widths in system clocks, per code 00..11
// ************************************************************
`define DCT_GF_W0           5'h01
`define DCT_GF_W1           5'h04
`define DCT_GF_W2           5'h08
`define DCT_GF_W3           5'h10

`endif

// File: rtl/dct_sync3.v
/*
 * Three-stage input synchroniser for a pin from outside the clock domain.
 * Assumes i_pin is asynchronous; the output moves only once stages two
 * and three agree.
 */
`timescale 1ns/1ps
module dct_sync3
(
   input  wire i_clk_sys,
   input  wire i_srst,
   input  wire i_ce,
   input  wire i_pin,
   output reg  o_level
);

   reg [2:0] stage_reg;

   always @(posedge i_clk_sys)
   begin
      if (i_srst)
      begin
         stage_reg <= 3'h0;
         o_level   <= 1'b0;
      end
      else if (i_ce)
      begin
         stage_reg <= {stage_reg[1:0], i_pin};
         // Stage 0 feeds only stage 1
         if (stage_reg[1] == stage_reg[2])
            o_level <= stage_reg[2];
      end
   end

endmodule

// File: rtl/dct_glitch_edge.v
/*
 * Glitch filter and edge detector for the demodulation input.
 * Assumes i_level is already synchronous to i_clk_sys.
 */
`timescale 1ns/1ps
`include "dct_map.vh"
module dct_glitch_edge
(
   input  wire       i_clk_sys,
   input  wire       i_srst,
   input  wire       i_ce,
   input  wire       i_level,
   input  wire [1:0] i_width_sel,
   output reg        o_pos_edge,
   output reg        o_neg_edge
);

   reg [4:0] stable_reg;
   reg       clean_reg;
   reg [4:0] width;

   always @*
   begin
      case (i_width_sel)
         2'h0:    width = `DCT_GF_W0;
         2'h1:    width = `DCT_GF_W1;
         2'h2:    width = `DCT_GF_W2;
         default: width = `DCT_GF_W3;
      endcase
   end

   always @(posedge i_clk_sys)
   begin
      if (i_srst)
      begin
         stable_reg <= 5'h00;
         clean_reg  <= 1'b0;
         o_pos_edge <= 1'b0;
         o_neg_edge <= 1'b0;
      end
      else if (i_ce)
      begin
         o_pos_edge <= 1'b0;
         o_neg_edge <= 1'b0;
         if (i_level == clean_reg)
            stable_reg <= 5'h00;
         // Pulse shorter than the width never reaches the edge lines
         else if (stable_reg + 5'h01 >= width)
         begin
            stable_reg <= 5'h00;
            clean_reg  <= i_level;
            o_pos_edge <= i_level;
            o_neg_edge <= ~i_level;
         end
         else
            stable_reg <= stable_reg + 5'h01;
      end
   end

endmodule

// File: tb/dct_top_checker.sv
/*
 * Port checker for the dual counter/timer control block.
 * Assumes it is bound to dct_top and sees only that module's ports.
 */
`timescale 1ns/1ps
`include "dct_map.vh"
module dct_top_checker
(
   input wire                   i_clk_sys,
   input wire                   i_srst,
   input wire                   i_ce,
   input wire [`DCT_ADDR_W-1:0] i_addr,
   input wire [7:0]             i_wr_data,
   input wire                   i_wr,
   input wire                   i_rd,
   input wire [7:0]             o_rd_data,
   input wire                   o_sixteen_counter_pin,
   input wire                   o_eight_counter_pin_oe_n,
   input wire                   o_sixteen_counter_pin_oe_n,
   input wire                   o_combined_output_pin_oe_n,
   input wire                   o_capture_req
);
   // ************************************************************
   // Register writes and pin relations
   // ************************************************************
   wire wr_s = i_ce && i_wr && i_addr == `DCT_OFS_SHARED;
   wire rd_y = i_ce && i_rd && i_addr == `DCT_OFS_SYNC;
   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (i_srst);
   rd_reserved_a: assert property (
      rd_y |=> o_rd_data[4:0] == 5'h1f) else $error("reserved bits wrong");
   sync_off_a: assert property (
      rd_y && $past(i_srst) |=> !o_rd_data[5]) else $error("sync on at reset");
   rst_state_a: assert property (
      $past(i_srst) && $past(i_ce) |-> o_rd_data == 8'h00 && !o_capture_req
      && o_eight_counter_pin_oe_n && o_combined_output_pin_oe_n)
      else $error("outputs not idle after reset");
   pin8_oe_a: assert property (
      i_ce && i_wr && i_addr == `DCT_OFS_CTL8 |=>
      o_eight_counter_pin_oe_n == !$past(i_wr_data[0]))
      else $error("eight pin enable wrong");
   pin16_oe_a: assert property (
      i_ce && i_wr && i_addr == `DCT_OFS_CTL16 |=>
      o_sixteen_counter_pin_oe_n == !$past(i_wr_data[0]))
      else $error("sixteen pin enable wrong");
   comb_oe_a: assert property (
      wr_s |=> o_combined_output_pin_oe_n ==
      !($past(i_wr_data[6]) && !$past(i_wr_data[7])))
      else $error("combined pin enable wrong");
   force_high_a: assert property (
      wr_s && !i_wr_data[7] && i_wr_data[3:2] == `DCT_SUB_FORCE1 &&
      !o_sixteen_counter_pin_oe_n |-> ##[1:3] o_sixteen_counter_pin)
      else $error("sixteen pin not forced high");
   force_low_a: assert property (
      wr_s && !i_wr_data[7] && i_wr_data[3:2] == `DCT_SUB_FORCE0 &&
      !o_sixteen_counter_pin_oe_n |-> ##[1:3] !o_sixteen_counter_pin)
      else $error("sixteen pin not forced low");
   cap_pulse_a: assert property (
      o_capture_req |=> !o_capture_req) else $error("capture not a pulse");
   cover property (o_capture_req);
   cover property (wr_s && i_wr_data[3:2] == `DCT_SUB_FORCE1);
   cover property (rd_y);
endmodule

bind dct_top dct_top_checker CHK
(
   .i_clk_sys                  (i_clk_sys),
   .i_srst                     (i_srst),
   .i_ce                       (i_ce),
   .i_addr                     (i_addr),
   .i_wr_data                  (i_wr_data),
   .i_wr                       (i_wr),
   .i_rd                       (i_rd),
   .o_rd_data                  (o_rd_data),
   .o_sixteen_counter_pin      (o_sixteen_counter_pin),
   .o_eight_counter_pin_oe_n   (o_eight_counter_pin_oe_n),
   .o_sixteen_counter_pin_oe_n (o_sixteen_counter_pin_oe_n),
   .o_combined_output_pin_oe_n (o_combined_output_pin_oe_n),
   .o_capture_req              (o_capture_req)
);

// File: tb/dct_pin_model.sv
/*
 * Modulated signal source on the two edge input pins.
 * Assumes the bench calls its tasks at clock edges; changes land 3 ns later.
 */
`timescale 1ns/1ps
module dct_pin_model
(
   output reg o_pin_a,
   output reg o_pin_b
);
   // ************************************************************
   // Source behaviour
   // ************************************************************
   initial
   begin
      o_pin_a = 1'b0;
      o_pin_b = 1'b0;
   end
   // Slow source: level held until the next call
   task set_a(input lvl);
      begin
         #3;
         o_pin_a = lvl;
      end
   endtask
   task set_b(input lvl);
      begin
         #3;
         o_pin_b = lvl;
      end
   endtask
   // Offset keeps pin changes clear of the sampling edge
   task pulse_a(input integer ns);
      begin
         #3;
         o_pin_a = ~o_pin_a;
         #ns;
         o_pin_a = ~o_pin_a;
      end
   endtask
endmodule

// File: tb/dct_top_test.sv
/*
 * Self-checking bench for the dual counter/timer control block.
 * Assumes the pin model on the edge inputs.
 */
`timescale 1ns/1ps
`include "dct_map.vh"
module dct_top_test;
   reg                    i_clk_sys = 1'b0;
   reg                    i_srst    = 1'b1;
   reg  [`DCT_ADDR_W-1:0] i_addr    = 4'h0;
   reg  [7:0]             i_wr_data = 8'h00;
   reg                    i_wr      = 1'b0;
   reg                    i_rd      = 1'b0;
   reg                    i_ce      = 1'b1;
   wire [7:0]             o_rd_data;
   wire                   pin_a, pin_b, p8, p16, pc, oe8, oe16, oec, cap;
   wire [7:0]             pins = {2'b00, oec, oe16, oe8, 1'b0, p16, p8};
   integer                err_count = 0;
   integer                compares  = 0;
   integer                caps      = 0;
   integer                cycles    = 0;
   integer                k;
   // Combined level per k = {logic code, forced sixteen level}
   reg  [7:0]             cmb = 8'h4e;

   dct_pin_model PIN (.o_pin_a(pin_a), .o_pin_b(pin_b));
   dct_top DUT
   (
      .i_clk_sys                  (i_clk_sys),
      .i_srst                     (i_srst),
      .i_ce                       (i_ce),
      .i_addr                     (i_addr),
      .i_wr_data                  (i_wr_data),
      .i_wr                       (i_wr),
      .i_rd                       (i_rd),
      .o_rd_data                  (o_rd_data),
      .i_edge_pin_a               (pin_a),
      .i_edge_pin_b               (pin_b),
      .o_eight_counter_pin        (p8),
      .o_sixteen_counter_pin      (p16),
      .o_combined_output_pin      (pc),
      .o_eight_counter_pin_oe_n   (oe8),
      .o_sixteen_counter_pin_oe_n (oe16),
      .o_combined_output_pin_oe_n (oec),
      .o_capture_req              (cap)
   );

   // ************************************************************
   // Clock, watchdog and shared tasks
   // ************************************************************
   always #12.5 i_clk_sys = ~i_clk_sys;
   always @(posedge i_clk_sys)
   begin
      cycles = cycles + 1;
      if (cap === 1'b1)
         caps = caps + 1;
      if (cycles == 3000)
      begin
         err_count = err_count + 1;
         test_done;
      end
   end
   task test_done;
      begin
         if (err_count == 0 && compares > 0)
            $display("Test passed");
         else
            $display("Test failed");
         $finish;
      end
   endtask
   task chk(input [7:0] got, input [7:0] exp);
      begin
         compares = compares + 1;
         if (got !== exp)
         begin
            err_count = err_count + 1;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   task bus(input w, input r, input [3:0] a, input [7:0] v);
      begin
         i_wr <= w;
         i_rd <= r;
         i_addr <= a;
         i_wr_data <= v;
         @(posedge i_clk_sys);
      end
   endtask
   task idle(input integer n);
      begin
         i_wr <= 1'b0;
         i_rd <= 1'b0;
         repeat (n) @(posedge i_clk_sys);
      end
   endtask
   // Pins settle two registers after the write, hence the gap
   task wr(input [3:0] a, input [7:0] v);
      begin
         bus(1'b1, 1'b0, a, v);
         idle(3);
      end
   endtask
   task rd(input [3:0] a, input [7:0] e);
      begin
         bus(1'b0, 1'b1, a, 8'h00);
         idle(1);
         chk(o_rd_data, e);
      end
   endtask

   // ************************************************************
   // Scenarios
   // ************************************************************
   initial
   begin
      repeat (3) @(posedge i_clk_sys);
      i_srst <= 1'b0;
      rd(`DCT_OFS_SYNC, 8'h1f);
      bus(1'b1, 1'b0, `DCT_OFS_SYNC, 8'h00);
      rd(`DCT_OFS_SYNC, 8'h1f);
      rd(`DCT_OFS_CTL8, 8'h00);
      wr(4'h9, 8'h5a);
      rd(4'h9, 8'h00);
      wr(`DCT_OFS_CTL8, 8'h01);
      wr(`DCT_OFS_CTL16, 8'h01);
      wr(`DCT_OFS_SHARED, 8'h00);
      chk(pins, 8'h23);
      wr(`DCT_OFS_SHARED, 8'h03);
      chk(pins, 8'h20);
      for (k = 0; k < 8; k = k + 1)
      begin
         wr(`DCT_OFS_SHARED, {2'b01, k[2:1], 1'b1, k[0], 2'b00});
         chk({7'h00, pc}, {7'h00, cmb[k]});
         chk(pins, {6'h00, k[0], 1'b1});
      end
      // Levels set before start, left alone while running
      wr(`DCT_OFS_SHARED, 8'h02);
      chk(pins, 8'h22);
      bus(1'b1, 1'b0, `DCT_OFS_HOLD8_LO, 8'h03);
      bus(1'b1, 1'b0, `DCT_OFS_HOLD8_HI, 8'h05);
      wr(`DCT_OFS_CTL8, 8'hc1);
      chk({7'h00, p8}, 8'h01);
      idle(20);
      rd(`DCT_OFS_CTL8, 8'h61);
      wr(`DCT_OFS_CTL8, 8'h21);
      rd(`DCT_OFS_CTL8, 8'h01);
      rd(`DCT_OFS_HOLD8_LO, 8'h03);
      rd(`DCT_OFS_HOLD8_HI, 8'h05);
      wr(`DCT_OFS_CTL8, 8'h04);
      wr(`DCT_OFS_SHARED, 8'h90);
      PIN.set_a(1'b1);
      idle(12);
      rd(`DCT_OFS_SHARED, 8'h92);
      wr(`DCT_OFS_SHARED, 8'h92);
      rd(`DCT_OFS_SHARED, 8'h90);
      PIN.set_a(1'b0);
      idle(12);
      rd(`DCT_OFS_SHARED, 8'h90);
      wr(`DCT_OFS_SHARED, 8'h80);
      PIN.set_a(1'b1);
      idle(12);
      PIN.set_a(1'b0);
      idle(12);
      rd(`DCT_OFS_SHARED, 8'h81);
      wr(`DCT_OFS_SHARED, 8'h95);
      caps = 0;
      PIN.pulse_a(50);
      idle(20);
      rd(`DCT_OFS_SHARED, 8'h94);
      PIN.pulse_a(250);
      idle(20);
      rd(`DCT_OFS_SHARED, 8'h96);
      chk(caps[7:0], 8'h01);
      chk({7'h00, oec}, 8'h01);
      wr(`DCT_OFS_SHARED, 8'h96);
      wr(`DCT_OFS_CTL16, 8'h02);
      PIN.set_b(1'b1);
      idle(20);
      rd(`DCT_OFS_SHARED, 8'h96);
      // Write with clock enable low must not land
      i_ce <= 1'b0;
      wr(`DCT_OFS_HOLD8_LO, 8'hff);
      i_ce <= 1'b1;
      rd(`DCT_OFS_HOLD8_LO, 8'h03);
      test_done;
   end
endmodule
